//--- hdl/csa_pkg.sv
// package for the channel status and alarm flag bank
package csa_pkg;

  // ****************************************
  // address map
  // ****************************************
  localparam int          CSA_ADDR_W       = 16;
  localparam logic [15:0] CSA_CH_STRIDE    = 16'h0100;
  localparam logic [15:0] CSA_STATE_OFS    = 16'h0101;
  localparam logic [15:0] CSA_ALARM_OFS    = 16'h0102;
  localparam logic [15:0] CSA_IRQ_STAT_OFS = 16'hff00;
  localparam logic [15:0] CSA_IRQ_MASK_OFS = 16'hff01;
  localparam int          CSA_NUM_CH       = 64;

  // ****************************************
  // status word field positions
  // ****************************************
  localparam int ST_STOP_BIT    = 0;
  localparam int ST_MANUAL_BIT  = 1;
  localparam int ST_TUNING_BIT  = 2;
  localparam int ST_PID_BIT     = 4;
  localparam int ST_INERR_BIT   = 8;
  localparam int ST_GT_ERR_BIT  = 12;
  localparam int ST_GTC_ERR_BIT = 13;

  // ****************************************
  // alarm word field positions
  // ****************************************
  localparam int AL_PROC1_BIT   = 0;
  localparam int AL_PROC2_BIT   = 1;
  localparam int AL_PROC3_BIT   = 2;
  localparam int AL_UNIT_ERR    = 10;
  localparam int AL_UNIT_ALM    = 11;
  localparam int AL_SP_RANGE    = 12;
  localparam int AL_SP_REV      = 13;
  localparam int AL_MV_REV      = 14;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] CSA_RDATA_RST = 16'h0000;
  localparam logic [1:0]  CSA_IRQ_RST   = 2'h0;

  // per-channel raw conditions from the control core
  typedef struct packed {
    logic       stopped;
    logic       manual;
    logic       auto_tuning;
    logic       gradient_tuning;
    logic       pid_type;
    logic       input_error;
    logic       gradient_tuning_error;
    logic       gradient_temperature_control_error;
    logic [2:0] process_alarm;
    logic       unit_input_error;
    logic       power_comm_error;
    logic       power_zero_cross_error;
    logic       peak_overcurrent;
    logic       heater_burnout;
    logic       heater_short;
    logic [15:0] set_point;
    logic [15:0] sp_upper;
    logic [15:0] sp_lower;
    logic [15:0] manipulated_value_upper;
    logic [15:0] manipulated_value_lower;
  } csa_cond_t;

endpackage : csa_pkg

//--- hdl/csa_flags.sv
// channel status and alarm flag register bank
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps

// How it works
// (RULE1) one status word and one alarm word per channel, channel-indexed address
// (RULE2) status bit 0 is 1 while stopped, 0 while running
// (RULE3) status bit 1 is 1 in manual mode, 0 in automatic
// (RULE4) status bit 2 is 1 while auto or gradient tuning runs
// (RULE5) status bit 4 is 0 for gradient control, 1 for PID
// (RULE6) status bit 8 is 1 while an input error exists
// (RULE7) status bit 12 is 1 after a gradient tuning error
// (RULE8) status bit 13 is 1 when gradient control parameters are in error
// (RULE9) alarm bits 0..2 follow process alarms 1..3
// (RULE10) alarm bit 10 on unit input error or power controller fault
// (RULE11) alarm bit 11 on peak overcurrent, heater burnout or short
// (RULE12) alarm bit 12 while set point is outside the limiter range; the code holds it at 0 while the set point limits are reversed
// (RULE13) alarm bit 13 while set point limits are reversed
// (RULE14) alarm bit 14 while output limits are reversed
// (RULE15) unused bits read zero and do nothing
// (RULE16) both words read-only and show the present condition
module csa_flags
  import csa_pkg::*;
#(
  parameter int NUM_CH = CSA_NUM_CH
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire csa_cond_t             cond      [NUM_CH],
  input  wire logic [CSA_ADDR_W-1:0] addr,
  input  wire logic [15:0]           wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic      [15:0]           rdata,
  output logic                       irq
);

  // ****************************************
  // flag word builders
  // ****************************************
  function automatic logic [15:0] state_word(input csa_cond_t c);
    logic [15:0] w;
    w                 = 16'h0000; // RULE15
    w[ST_STOP_BIT]    = c.stopped; // RULE2
    w[ST_MANUAL_BIT]  = c.manual; // RULE3
    w[ST_TUNING_BIT]  = c.auto_tuning | c.gradient_tuning; // RULE4
    w[ST_PID_BIT]     = c.pid_type; // RULE5
    w[ST_INERR_BIT]   = c.input_error; // RULE6
    w[ST_GT_ERR_BIT]  = c.gradient_tuning_error; // RULE7
    w[ST_GTC_ERR_BIT] = c.gradient_temperature_control_error; // RULE8
    return w;
  endfunction : state_word

  function automatic logic [15:0] alarm_word(input csa_cond_t c);
    logic [15:0] w;
    logic        sp_rev;
    w                = 16'h0000; // RULE15
    sp_rev           = $signed(c.sp_upper) < $signed(c.sp_lower);
    w[AL_PROC1_BIT]  = c.process_alarm[0]; // RULE9
    w[AL_PROC2_BIT]  = c.process_alarm[1]; // RULE9
    w[AL_PROC3_BIT]  = c.process_alarm[2]; // RULE9
    w[AL_UNIT_ERR]   = c.unit_input_error | c.power_comm_error
                       | c.power_zero_cross_error; // RULE10
    w[AL_UNIT_ALM]   = c.peak_overcurrent | c.heater_burnout | c.heater_short; // RULE11
    w[AL_SP_RANGE]   = !sp_rev && ($signed(c.set_point) > $signed(c.sp_upper)
                       || $signed(c.set_point) < $signed(c.sp_lower)); // RULE12
    w[AL_SP_REV]     = sp_rev; // RULE13
    w[AL_MV_REV]     = $signed(c.manipulated_value_upper)
                       < $signed(c.manipulated_value_lower); // RULE14
    return w;
  endfunction : alarm_word

  // ****************************************
  // per-channel words
  // ****************************************
  logic [15:0] st_w  [NUM_CH];
  logic [15:0] al_w  [NUM_CH];
  logic [NUM_CH-1:0] st_any;
  logic [NUM_CH-1:0] al_any;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    assign st_w[g]   = state_word(cond[g]);
    assign al_w[g]   = alarm_word(cond[g]);
    assign st_any[g] = |st_w[g][ST_GTC_ERR_BIT:ST_INERR_BIT];
    assign al_any[g] = |al_w[g];
  end

  // ****************************************
  // interrupt events
  // ****************************************
  logic [1:0] err_lvl_r;
  logic [1:0] err_rise;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  logic [1:0] irq_stat_nxt;
  logic [1:0] irq_mask_nxt;
  logic       stat_rd;
  logic       mask_wr;

  // bit 0: rise of the OR of all channel errors, bit 1: rise of the OR of all alarms
  assign err_rise     = {|al_any, |st_any} & ~err_lvl_r;
  assign stat_rd      = rd && addr == CSA_IRQ_STAT_OFS;
  assign mask_wr      = wr && addr == CSA_IRQ_MASK_OFS;
  // read clears, but a same-cycle event wins
  assign irq_stat_nxt = (stat_rd ? 2'h0 : irq_stat_r) | err_rise;
  assign irq_mask_nxt = mask_wr ? wdata[1:0] : irq_mask_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      err_lvl_r <= CSA_IRQ_RST;
    end else begin
      err_lvl_r <= {|al_any, |st_any};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat_r <= CSA_IRQ_RST;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_mask_r <= CSA_IRQ_RST;
    end else if (mask_wr) begin
      irq_mask_r <= wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_nxt & irq_mask_nxt);
    end
  end

  // ****************************************
  // read port
  // ****************************************
  logic [15:0] rdata_nxt;
  logic [7:0]  ch_hi;

  assign ch_hi = addr[15:8];

  // true when the address hits word ofs of a channel that exists
  function automatic logic ch_hit(input logic [15:0] a, input logic [7:0] ofs);
    return a[15:8] >= 8'h01 && a[15:8] <= 8'(NUM_CH) && a[7:0] == ofs;
  endfunction : ch_hit

  always_comb begin
    rdata_nxt = 16'h0000;
    if (addr == CSA_IRQ_STAT_OFS) begin
      rdata_nxt = {14'h0, irq_stat_r};
    end else if (addr == CSA_IRQ_MASK_OFS) begin
      rdata_nxt = {14'h0, irq_mask_r};
    end else if (ch_hit(addr, CSA_STATE_OFS[7:0])) begin
      rdata_nxt = st_w[6'(ch_hi - 8'h01)]; // RULE1 RULE16
    end else if (ch_hit(addr, CSA_ALARM_OFS[7:0])) begin
      rdata_nxt = al_w[6'(ch_hi - 8'h01)]; // RULE1 RULE16
    end
  end

  // writes to flag words are ignored
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= CSA_RDATA_RST;
    end else if (rd) begin
      rdata <= rdata_nxt;
    end else begin
      rdata <= CSA_RDATA_RST;
    end
  end

endmodule : csa_flags

//--- dv/csa_flags_assertions.sv
// assertions for the channel status and alarm flag bank
`timescale 1ns/1ps
module csa_flags_assertions
  import csa_pkg::*;
#(
  parameter int NUM_CH = CSA_NUM_CH
) (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire csa_cond_t             cond [NUM_CH],
  input wire logic [CSA_ADDR_W-1:0] addr,
  input wire logic [15:0]           wdata,
  input wire logic                  wr,
  input wire logic                  rd,
  input wire logic [15:0]           rdata,
  input wire logic                  irq
);
  function automatic logic [15:0] st_f(csa_cond_t c);
    st_f = {2'h0, c.gradient_temperature_control_error, c.gradient_tuning_error, 3'h0,
      c.input_error, 3'h0, c.pid_type, 1'b0, c.auto_tuning | c.gradient_tuning, c.manual,
      c.stopped};
  endfunction : st_f
  function automatic logic [15:0] al_f(csa_cond_t c);
    logic rev;
    logic out;
    rev = $signed(c.sp_upper) < $signed(c.sp_lower);
    out = !rev && ($signed(c.set_point) > $signed(c.sp_upper) ||
      $signed(c.set_point) < $signed(c.sp_lower));
    al_f = {1'b0, $signed(c.manipulated_value_upper) < $signed(c.manipulated_value_lower),
      rev, out, c.peak_overcurrent | c.heater_burnout | c.heater_short,
      c.unit_input_error | c.power_comm_error | c.power_zero_cross_error, 7'h00,
      c.process_alarm};
  endfunction : al_f
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  idle_zero_a: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data not zero outside a read");
  st_word_a: assert property (rd && addr == 16'h0101 |=> rdata == st_f($past(cond[0])))
    else $error("channel 1 status word wrong");
  al_word_a: assert property (rd && addr == 16'h0102 |=> rdata == al_f($past(cond[0])))
    else $error("channel 1 alarm word wrong");
  st_last_a: assert property ($past(rd) && $past(addr) == 16'h4001 |->
    rdata == st_f($past(cond[NUM_CH-1])))
    else $error("last channel status word wrong");
  al_last_a: assert property (rd && addr == 16'h4002 ##1 1'b1 |->
    rdata == al_f($past(cond[NUM_CH-1])))
    else $error("last channel alarm word wrong");
  st_unused_a: assert property (rd && addr[7:0] == 8'h01 |=> (rdata & 16'hcee8) == 16'h0)
    else $error("unused status bit set");
  al_unused_a: assert property (rd && addr[7:0] == 8'h02 |=> (rdata & 16'h83f8) == 16'h0)
    else $error("unused alarm bit set");
  unmapped_a: assert property (rd && addr == 16'h0103 |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  cover property (irq);
  cover property (rd && addr == CSA_IRQ_STAT_OFS);
  cover property (rdata[AL_SP_REV]);
endmodule : csa_flags_assertions

bind csa_flags csa_flags_assertions #(.NUM_CH(NUM_CH)) u_chk (.clk(clk), .rst(rst),
  .cond(cond), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));

//--- dv/csa_flags_bench.sv
// self-checking bench for the channel status and alarm flag bank
`timescale 1ns/1ps
module csa_flags_bench;
  import csa_pkg::*;
  logic        clk, rst, wr, rd, irq;
  logic [15:0] addr, wdata, rdata;
  csa_cond_t   cond [CSA_NUM_CH];
  int          bad_count, comparisons, cycles;
  csa_flags i_dut (.clk(clk), .rst(rst), .cond(cond), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task print_verdict;
    if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task chk(string n, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task rchk(logic [15:0] a, logic [15:0] e, string n);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk(n, e, rdata);
  endtask : rchk
  task wr_reg(logic [15:0] a, logic [15:0] w);
    @(posedge clk);
    addr <= a;
    wdata <= w;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask : wr_reg
  task setc(csa_cond_t c);
    @(posedge clk);
    cond[0] <= c;
  endtask : setc
  task t_status;
    csa_cond_t c;
    c = '0;
    rchk(16'h0101, 16'h0000, "status idle");
    c.stopped = 1; c.manual = 1; c.auto_tuning = 1; c.pid_type = 1; c.input_error = 1;
    c.gradient_tuning_error = 1; c.gradient_temperature_control_error = 1;
    setc(c);
    rchk(16'h0101, 16'h3117, "status all");
    wr_reg(16'h0101, 16'h0000);
    rchk(16'h0101, 16'h3117, "status read only");
    c = '0;
    c.gradient_tuning = 1;
    setc(c);
    rchk(16'h0101, 16'h0004, "status gt");
    @(posedge clk);
    cond[63].stopped <= 1;
    rchk(16'h4001, 16'h0001, "status ch64");
    rchk(16'h4002, 16'h0000, "alarm ch64");
    rchk(16'h0103, 16'h0000, "unmapped");
  endtask : t_status
  task t_alarm;
    csa_cond_t c;
    c = '0;
    c.sp_upper = 16'h0064; c.sp_lower = 16'hff9c; c.set_point = 16'h00c8;
    c.process_alarm = 3'h5; c.unit_input_error = 1; c.heater_short = 1;
    setc(c);
    rchk(16'h0102, 16'h1c05, "alarm high sp");
    c.set_point = 16'hff38; c.process_alarm = 3'h2; c.unit_input_error = 0;
    c.power_zero_cross_error = 1; c.heater_short = 0; c.peak_overcurrent = 1;
    setc(c);
    rchk(16'h0102, 16'h1c02, "alarm low sp");
    c = '0;
    c.sp_upper = 16'hfffb; c.sp_lower = 16'h0005; c.set_point = 16'h0064;
    c.manipulated_value_upper = 16'hffff; c.manipulated_value_lower = 16'h0001;
    c.power_comm_error = 1;
    setc(c);
    rchk(16'h0102, 16'h6400, "alarm reversed");
    c = '0;
    c.sp_upper = 16'h0064; c.set_point = 16'h0064; c.heater_burnout = 1;
    setc(c);
    rchk(16'h0102, 16'h0800, "alarm sp edge");
  endtask : t_alarm
  task t_irq;
    csa_cond_t c;
    c = '0;
    setc(c);
    rchk(16'hff00, 16'h0003, "irq status sticky");
    wr_reg(16'hff01, 16'h0003);
    rchk(16'hff01, 16'h0003, "irq mask");
    c.input_error = 1;
    setc(c);
    repeat (3) @(posedge clk);
    #1 chk("irq raised", 16'h0001, {15'h0, irq});
    rchk(16'hff00, 16'h0001, "irq status");
    repeat (2) @(posedge clk);
    #1 chk("irq cleared", 16'h0000, {15'h0, irq});
    wr_reg(16'hff01, 16'h0000);
    c.process_alarm = 3'h1;
    setc(c);
    repeat (3) @(posedge clk);
    #1 chk("irq masked", 16'h0000, {15'h0, irq});
    rchk(16'hff00, 16'h0002, "irq alarm status");
  endtask : t_irq
  initial begin
    rst = 1; wr = 0; rd = 0; addr = 0; wdata = 0;
    for (int i = 0; i < CSA_NUM_CH; i++) cond[i] = '0;
    repeat (8) @(posedge clk);
    rst <= 0;
    t_status;
    t_alarm;
    t_irq;
    print_verdict;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      print_verdict;
    end
  end
endmodule : csa_flags_bench
